// ==== hdl/cpi_defs.svh ====
`ifndef CPI_DEFS_SVH
`define CPI_DEFS_SVH
`define CPI_TM_PUSH      3'h0
`define CPI_TM_WRITE     3'h1
`define CPI_SIZ_LONG     2'h0
`define CPI_SIZ_LINE     2'h3
`define CPI_SNOOP_DIRTY  2'h1
`define CPI_SNOOP_INVAL  2'h2
`define CPI_FIFO_DEPTH   8
`define CPI_LFSR_SEED    8'hA5
`define CPI_SETS         16
`endif

// ==== hdl/cpi_fifo.sv ====
`timescale 1ns/1ps
`default_nettype none
module cpi_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 8
) (
   input  wire logic             clock_in,
   input  wire logic             rstn_in,
   input  wire logic             in_valid_in,
   output logic                  in_ready_out,
   input  wire logic [WIDTH-1:0] in_data_in,
   output logic                  out_valid_out,
   input  wire logic             out_ready_in,
   output logic      [WIDTH-1:0] out_data_out
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem_q [DEPTH];
   logic [AW:0]      wr_q;
   logic [AW:0]      rd_q;
   logic             push;
   logic             pop;
   assign in_ready_out  = (wr_q - rd_q) != (AW+1)'(DEPTH);
   assign out_valid_out = wr_q != rd_q;
   assign out_data_out  = mem_q[rd_q[AW-1:0]];
   assign push = in_valid_in && in_ready_out;
   assign pop  = out_valid_out && out_ready_in;
   always_ff @(posedge clock_in) begin
      if (!rstn_in) begin
         wr_q <= '0;
         rd_q <= '0;
      end else begin
         if (push) begin
            wr_q <= wr_q + 1'b1;
         end
         if (pop) begin
            rd_q <= rd_q + 1'b1;
         end
      end
      if (push) begin
         mem_q[wr_q[AW-1:0]] <= in_data_in;
      end
   end
endmodule
`default_nettype wire

// ==== hdl/cpi_pkg.sv ====
package cpi_pkg;
   typedef enum logic [2:0] {
      CPI_IDLE, CPI_FETCH, CPI_LOAD, CPI_LONG, CPI_LINE, CPI_SPLIT, CPI_DONE
   } cpi_state_t;
   typedef struct packed {
      logic [27:0]  line_addr;
      logic [127:0] data;
      logic [3:0]   dirty;
      logic [1:0]   way;
      logic         locked;
   } cpi_victim_t;
   typedef struct packed {
      logic [31:0] addr;
      logic [31:0] data;
      logic [2:0]  tm;
      logic [1:0]  siz;
      logic        lock;
   } cpi_beat_t;
endpackage

// ==== hdl/cpi_push_icache.sv ====
// Summary of operation
// - dirty victim goes to push buffer; new line fetched before write-back
// - buffered line is snoopable; execution units cannot reach it
// - after good fill, write buffered line back then drop the buffer
// - fill error restores victim to its original way; cache inhibit skips the fill and pushes
// - one dirty long word is pushed as a single long-word transfer
// - transfer modifier is 000 on every push beat
// - ack plus error ack retries a long-word push; error ack alone errors
// - bus error on long-word push raises exception at once
// - two or more dirty long words push as a burst line transfer
// - burst inhibit ends line access; remaining three go as long writes
// - retry honoured only on first line beat; later retry is bus error
// - bus error on any line push beat raises exception at once
// - inhibited access hitting dirty line pushes first, with lock if locked
// - instruction lines are only invalid or valid
// - physical address bit 3 picks half line for instruction bus
// - miss fills an invalid way, writes tag and data, sets valid
// - all ways valid: pseudo-random victim among four ways
// - drop or flush op invalidates a valid instruction line, no bus
// - snoop read under leave-dirty mode leaves instruction lines alone
// - snoop read under invalidate, or snoop write under leave-dirty or invalidate, invalidates on hit
`timescale 1ns/1ps
`include "cpi_defs.svh"
`default_nettype none
module cpi_push_icache (
   input  wire logic                 clock_in,
   input  wire logic                 rstn_in,
   // victim from the data cache
   input  wire logic                 victim_valid_in,
   output logic                      victim_ready_out,
   input  wire cpi_pkg::cpi_victim_t victim_in,
   input  wire logic                 victim_inhibit_in,
   // replacement line fill outcome
   input  wire logic                 fill_done_in,
   input  wire logic                 fill_abort_in,
   output logic                      restore_valid_out,
   output cpi_pkg::cpi_victim_t      restore_out,
   // snoop of the push buffer
   input  wire logic                 snoop_valid_in,
   input  wire logic [27:0]          snoop_line_in,
   output logic                      snoop_hit_out,
   output logic                      exec_block_out,
   // processor bus write side
   output logic                      bus_valid_out,
   output cpi_pkg::cpi_beat_t        bus_beat_out,
   input  wire logic                 transfer_acknowledge_in,
   input  wire logic                 transfer_error_acknowledge_in,
   input  wire logic                 burst_inhibit_in,
   output logic                      bus_exception_out,
   output logic                      push_busy_out,
   // instruction cache
   input  wire logic                 ic_fetch_in,
   input  wire logic [31:0]          ic_addr_in,
   output logic                      ic_hit_out,
   output logic [63:0]               ic_data_out,
   input  wire logic                 ic_fill_in,
   input  wire logic [127:0]         ic_fill_data_in,
   input  wire logic                 ic_drop_in,
   input  wire logic                 ic_snoop_in,
   input  wire logic                 ic_snoop_write_in,
   input  wire logic [1:0]           ic_snoop_mode_in,
   input  wire logic [31:0]          ic_snoop_addr_in
);
   localparam int SETS = `CPI_SETS;
   // ****************************************************************
   // push controller
   // ****************************************************************
   typedef struct packed {
      cpi_pkg::cpi_state_t  st;
      cpi_pkg::cpi_victim_t buf_line;
      logic                 buf_valid;
      logic [1:0]           beat;
      logic                 restore;
      logic                 exc;
      logic                 drain;
   } cpi_push_st_t;
   cpi_push_st_t q, d;
   cpi_pkg::cpi_beat_t f_in;
   logic f_in_valid;
   logic f_in_ready;
   logic f_out_valid;
   logic f_out_ready;
   logic ack;
   logic err;
   logic retry;

   function automatic logic [2:0] cpi_popcount(input logic [3:0] v);
      cpi_popcount = 3'(v[0]) + 3'(v[1]) + 3'(v[2]) + 3'(v[3]);
   endfunction

   function automatic logic [1:0] cpi_first_dirty(input logic [3:0] v);
      cpi_first_dirty = v[0] ? 2'h0 : v[1] ? 2'h1 : v[2] ? 2'h2 : 2'h3;
   endfunction

   // a beat is in flight while it sits at the fifo head; answers apply to it
   assign ack   = bus_valid_out && transfer_acknowledge_in;
   assign err   = bus_valid_out && transfer_error_acknowledge_in;
   assign retry = ack && err;
   // after a bus error the rest of the line is dropped off the bus
   assign f_out_ready = (ack && !err) || q.drain;

   always_comb begin
      d = q;
      d.restore = 1'b0;
      d.exc = 1'b0;
      if (!f_out_valid) begin
         d.drain = 1'b0;
      end
      f_in_valid = 1'b0;
      f_in.addr = {q.buf_line.line_addr, q.beat, 2'h0};
      f_in.data = q.buf_line.data[32*q.beat +: 32];
      f_in.tm = `CPI_TM_PUSH;
      f_in.siz = `CPI_SIZ_LONG;
      f_in.lock = q.buf_line.locked;
      unique case (q.st)
         cpi_pkg::CPI_IDLE: begin
            if (victim_valid_in && !q.drain) begin
               d.buf_line = victim_in;
               d.buf_valid = 1'b1;
               // inhibited access pushes before its own bus access
               d.st = victim_inhibit_in ? cpi_pkg::CPI_LOAD
                                        : cpi_pkg::CPI_FETCH;
            end
         end
         cpi_pkg::CPI_FETCH: begin
            if (fill_abort_in) begin
               d.restore = 1'b1;
               d.buf_valid = 1'b0;
               d.st = cpi_pkg::CPI_IDLE;
            end else if (fill_done_in) begin
               d.st = cpi_pkg::CPI_LOAD;
            end
         end
         cpi_pkg::CPI_LOAD: begin
            if (cpi_popcount(q.buf_line.dirty) == 3'h1) begin
               d.beat = cpi_first_dirty(q.buf_line.dirty);
               d.st = cpi_pkg::CPI_LONG;
            end else if (q.buf_line.dirty == 4'h0) begin
               d.buf_valid = 1'b0;
               d.st = cpi_pkg::CPI_IDLE;
            end else begin
               d.beat = 2'h0;
               d.st = cpi_pkg::CPI_LINE;
            end
         end
         cpi_pkg::CPI_LONG: begin
            f_in_valid = 1'b1;
            if (f_in_ready) begin
               d.st = cpi_pkg::CPI_DONE;
            end
         end
         cpi_pkg::CPI_LINE: begin
            // later beats wait until the first one is taken as a burst
            f_in_valid = q.beat == 2'h0 || !f_out_valid
                         || bus_beat_out.addr[3:2] != 2'h0;
            f_in.siz = `CPI_SIZ_LINE;
            if (f_in_ready && f_in_valid) begin
               d.beat = q.beat + 2'h1;
               if (q.beat == 2'h3) begin
                  d.st = cpi_pkg::CPI_DONE;
               end
            end
         end
         cpi_pkg::CPI_SPLIT: begin
            f_in_valid = q.beat != 2'h0;
            if (f_in_ready && f_in_valid) begin
               d.beat = q.beat + 2'h1;
               if (q.beat == 2'h3) begin
                  d.st = cpi_pkg::CPI_DONE;
               end
            end
         end
         cpi_pkg::CPI_DONE: begin
            if (!f_out_valid) begin
               d.buf_valid = 1'b0;
               d.st = cpi_pkg::CPI_IDLE;
            end
         end
         default: d.st = cpi_pkg::CPI_IDLE;
      endcase
      // bus answers on the beat leaving the fifo
      if (f_out_valid && bus_beat_out.siz == `CPI_SIZ_LINE && ack && !err
          && burst_inhibit_in && bus_beat_out.addr[3:2] == 2'h0) begin
         d.st = cpi_pkg::CPI_SPLIT;
         d.beat = 2'h1;
      end
      // retry only on a long-word push or the first beat of a burst
      if (err && !(retry && ((cpi_popcount(q.buf_line.dirty) == 3'h1)
          || (bus_beat_out.siz == `CPI_SIZ_LINE
              && bus_beat_out.addr[3:2] == 2'h0)))) begin
         d.exc = 1'b1;
         d.drain = 1'b1;
         d.buf_valid = 1'b0;
         d.st = cpi_pkg::CPI_IDLE;
      end
   end

   always_ff @(posedge clock_in) begin
      if (!rstn_in) begin
         q <= '0;
      end else begin
         q <= d;
      end
   end

   // pending beats are lost on an error; the fifo only holds this line
   cpi_fifo #(
      .WIDTH ($bits(cpi_pkg::cpi_beat_t)),
      .DEPTH (`CPI_FIFO_DEPTH)
   ) u_fifo (
      .clock_in      (clock_in),
      .rstn_in       (rstn_in),
      .in_valid_in   (f_in_valid),
      .in_ready_out  (f_in_ready),
      .in_data_in    (f_in),
      .out_valid_out (f_out_valid),
      .out_ready_in  (f_out_ready),
      .out_data_out  (bus_beat_out)
   );

   assign bus_valid_out     = f_out_valid && !q.drain;
   assign victim_ready_out  = q.st == cpi_pkg::CPI_IDLE && !q.drain;
   assign restore_valid_out = q.restore;
   assign restore_out       = q.buf_line;
   assign bus_exception_out = q.exc;
   assign push_busy_out     = q.st != cpi_pkg::CPI_IDLE || q.drain;
   assign exec_block_out    = q.buf_valid;
   assign snoop_hit_out     = snoop_valid_in && q.buf_valid
                              && snoop_line_in == q.buf_line.line_addr;

   // ****************************************************************
   // instruction cache line state
   // ****************************************************************
   typedef struct packed {
      logic [SETS-1:0][3:0] valid;
      logic [7:0]           lfsr;
      logic [63:0]          data;
      logic                 hit;
   } cpi_ic_st_t;
   cpi_ic_st_t iq, id;
   logic [23:0]  tag_q [SETS][4];
   logic [127:0] line_q [SETS][4];
   logic [3:0]   fset;
   logic [1:0]   fway;
   logic [3:0]   sset;
   logic [3:0]   fhit;
   logic [3:0]   shit;

   function automatic logic [3:0] cpi_match(input logic [31:0] a,
                                            input logic [3:0] vld,
                                            input logic [23:0] t0,
                                            input logic [23:0] t1,
                                            input logic [23:0] t2,
                                            input logic [23:0] t3);
      cpi_match = vld & {t3 == a[31:8], t2 == a[31:8],
                         t1 == a[31:8], t0 == a[31:8]};
   endfunction

   assign fset = ic_addr_in[7:4];
   assign sset = ic_snoop_addr_in[7:4];
   assign fhit = cpi_match(ic_addr_in, iq.valid[fset], tag_q[fset][0],
                           tag_q[fset][1], tag_q[fset][2], tag_q[fset][3]);
   assign shit = cpi_match(ic_snoop_addr_in, iq.valid[sset],
                           tag_q[sset][0], tag_q[sset][1],
                           tag_q[sset][2], tag_q[sset][3]);

   always_comb begin
      id = iq;
      id.hit = 1'b0;
      id.lfsr = {iq.lfsr[6:0], iq.lfsr[7] ^ iq.lfsr[5] ^ iq.lfsr[4]
                 ^ iq.lfsr[3]};
      // prefer an invalid way before random replacement
      fway = iq.lfsr[1:0];
      for (int w = 3; w >= 0; w--) begin
         if (!iq.valid[fset][w]) begin
            fway = 2'(w);
         end
      end
      if (ic_fetch_in && fhit != 4'h0) begin
         id.hit = 1'b1;
         for (int w = 0; w < 4; w++) begin
            if (fhit[w]) begin
               id.data = ic_addr_in[3] ? line_q[fset][w][127:64]
                                       : line_q[fset][w][63:0];
            end
         end
      end
      if (ic_fill_in) begin
         id.valid[fset][fway] = 1'b1;
      end
      if (ic_drop_in) begin
         id.valid[fset] = iq.valid[fset] & ~fhit;
      end
      if (ic_snoop_in && (ic_snoop_write_in
          ? (ic_snoop_mode_in == `CPI_SNOOP_DIRTY
             || ic_snoop_mode_in == `CPI_SNOOP_INVAL)
          : ic_snoop_mode_in == `CPI_SNOOP_INVAL)) begin
         id.valid[sset] = id.valid[sset] & ~shit;
      end
   end

   always_ff @(posedge clock_in) begin
      if (!rstn_in) begin
         iq <= '0;
         iq.lfsr <= `CPI_LFSR_SEED;
      end else begin
         iq <= id;
      end
      if (ic_fill_in) begin
         tag_q[fset][fway]  <= ic_addr_in[31:8];
         line_q[fset][fway] <= ic_fill_data_in;
      end
   end

   assign ic_hit_out  = iq.hit;
   assign ic_data_out = iq.data;
endmodule
`default_nettype wire

// ==== test/cpi_push_icache_asserts.sv ====
`timescale 1ns/1ps
`default_nettype none
// ****************
// push side checks
// ****************
module cpi_push_icache_asserts (
   input wire logic                 clock_in,
   input wire logic                 rstn_in,
   input wire logic                 victim_valid_in,
   input wire logic                 victim_ready_out,
   input wire cpi_pkg::cpi_victim_t victim_in,
   input wire logic                 victim_inhibit_in,
   input wire logic                 fill_done_in,
   input wire logic                 fill_abort_in,
   input wire logic                 restore_valid_out,
   input wire logic                 snoop_hit_out,
   input wire logic                 exec_block_out,
   input wire logic                 bus_valid_out,
   input wire cpi_pkg::cpi_beat_t   bus_beat_out,
   input wire logic                 transfer_acknowledge_in,
   input wire logic                 transfer_error_acknowledge_in,
   input wire logic                 bus_exception_out
);
   default clocking cb @(posedge clock_in); endclocking
   default disable iff (!rstn_in);
   logic wait_q;
   logic lock_q;
   logic ack;
   logic err;
   assign ack = transfer_acknowledge_in;
   assign err = transfer_error_acknowledge_in;
   // fill pending; lock only counts for inhibited victims
   always_ff @(posedge clock_in) begin
      if (!rstn_in) begin
         wait_q <= 1'b0;
         lock_q <= 1'b0;
      end else if (victim_valid_in && victim_ready_out) begin
         wait_q <= !victim_inhibit_in;
         lock_q <= victim_in.locked && victim_inhibit_in;
      end else if (fill_done_in || fill_abort_in) begin
         wait_q <= 1'b0;
      end
   end
   chk_fill_first: assert property (
      wait_q |-> !bus_valid_out)
      else $error("push beat before fill ended");
   chk_block_set: assert property (
      victim_valid_in && victim_ready_out |=> exec_block_out)
      else $error("buffer not blocked");
   chk_snoop_idle: assert property (
      !exec_block_out |-> !snoop_hit_out)
      else $error("snoop hit on empty buffer");
   chk_restore_pulse: assert property (
      wait_q && fill_abort_in |-> ##[1:2] restore_valid_out)
      else $error("no restore after abort");
   chk_tm_zero: assert property (
      bus_valid_out |-> bus_beat_out.tm == 3'h0)
      else $error("push modifier not zero");
   chk_beat_hold: assert property (
      bus_valid_out && !ack && !err
      |=> bus_valid_out && $stable(bus_beat_out))
      else $error("beat changed before answer");
   chk_err_exc: assert property (
      bus_valid_out && err && !ack |-> ##[1:2] bus_exception_out)
      else $error("no exception on bus error");
   chk_size_code: assert property (
      bus_valid_out |-> bus_beat_out.siz inside {2'h0, 2'h3})
      else $error("bad size code");
   chk_lock_push: assert property (
      bus_valid_out |-> bus_beat_out.lock == lock_q)
      else $error("lock wrong on push");
   cover property (restore_valid_out);
   cover property (bus_exception_out);
   cover property (bus_valid_out && ack && err);
endmodule
bind cpi_push_icache cpi_push_icache_asserts cpi_push_icache_asserts_i (
   .clock_in, .rstn_in, .victim_valid_in, .victim_ready_out, .victim_in,
   .victim_inhibit_in, .fill_done_in, .fill_abort_in, .restore_valid_out,
   .snoop_hit_out, .exec_block_out, .bus_valid_out, .bus_beat_out,
   .transfer_acknowledge_in, .transfer_error_acknowledge_in,
   .bus_exception_out);
`default_nettype wire

// ==== test/cpi_push_icache_tb_top.sv ====
`timescale 1ns/1ps
`default_nettype none
module cpi_push_icache_tb_top;
   logic clock_in, rstn_in, victim_valid_in, victim_ready_out;
   logic victim_inhibit_in, fill_done_in, fill_abort_in, restore_valid_out;
   logic snoop_valid_in, snoop_hit_out, exec_block_out, bus_valid_out;
   logic transfer_acknowledge_in, transfer_error_acknowledge_in;
   logic burst_inhibit_in, bus_exception_out, push_busy_out, ic_fetch_in;
   logic ic_hit_out, ic_fill_in, ic_drop_in, ic_snoop_in, ic_snoop_write_in;
   logic [1:0]           ic_snoop_mode_in;
   logic [27:0]          snoop_line_in;
   logic [31:0]          ic_addr_in, ic_snoop_addr_in;
   logic [63:0]          ic_data_out;
   logic [127:0]         ic_fill_data_in;
   cpi_pkg::cpi_victim_t victim_in, restore_out;
   cpi_pkg::cpi_beat_t   bus_beat_out, b;
   int                   checks = 0, n_mismatch = 0, base, nexc, nrst, hits;
   logic [1:0]           rway;
   cpi_push_icache cpi_push_icache_i (.*);
   cpi_slave_model cpi_slave_model_i (.clock_in, .rstn_in,
      .bus_valid_in(bus_valid_out), .beat_in(bus_beat_out),
      .ack_out(transfer_acknowledge_in),
      .err_out(transfer_error_acknowledge_in), .bi_out(burst_inhibit_in));
   initial begin
      clock_in = 1'b0;
      forever #20 clock_in = ~clock_in;
   end
   always @(posedge clock_in) begin
      if (bus_exception_out) nexc++;
      if (restore_valid_out) nrst++;
      if (restore_valid_out) rway = restore_out.way;
   end
   task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
      checks++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic tick(input int n);
      repeat (n) @(negedge clock_in);
   endtask
   task automatic push(input logic [3:0] d, input logic inh, input logic ab);
      int k;
      base = cpi_slave_model_i.cnt;
      nexc = 0;
      nrst = 0;
      victim_in.dirty = d;
      victim_in.locked = inh;
      victim_inhibit_in = inh;
      victim_valid_in = 1'b1;
      tick(1);
      victim_valid_in = 1'b0;
      snoop_valid_in = 1'b1;
      #1 chk(snoop_hit_out, 1'b1);
      chk(exec_block_out, 1'b1);
      snoop_valid_in = 1'b0;
      if (!inh) begin
         tick(2);
         chk(bus_valid_out, 1'b0);
         {fill_abort_in, fill_done_in} = {ab, !ab};
         tick(1);
         {fill_abort_in, fill_done_in} = 2'h0;
      end
      for (k = 0; k < 300 && !(victim_ready_out && !push_busy_out); k++)
         tick(1);
      chk(k < 300, 1'b1);
      chk(exec_block_out, 1'b0);
      tick(2);
   endtask
   // beat i must carry long word k of the victim, with that size code
   task automatic beat_is(input int i, input logic [1:0] k,
                          input logic [1:0] s);
      b = cpi_slave_model_i.log_q[i];
      chk(b.addr, {victim_in.line_addr, k, 2'h0});
      chk(b.data, victim_in.data[32*k +: 32]);
      chk({b.siz, b.tm}, {s, 3'h0});
   endtask
   task automatic t_push;
      int k;
      cpi_slave_model_i.retry_at = cpi_slave_model_i.cnt;
      cpi_slave_model_i.wait_n = 1;
      push(4'h4, 1'b0, 1'b0);
      cpi_slave_model_i.wait_n = 0;
      chk(cpi_slave_model_i.cnt - base, 1);
      beat_is(base, 2'h2, 2'h0);
      push(4'h3, 1'b0, 1'b0);
      chk(cpi_slave_model_i.cnt - base, 4);
      for (k = 0; k < 4; k++) beat_is(base + k, k, 2'h3);
      cpi_slave_model_i.bi_en = 1'b1;
      push(4'hA, 1'b0, 1'b0);
      cpi_slave_model_i.bi_en = 1'b0;
      chk(cpi_slave_model_i.cnt - base, 4);
      beat_is(base, 2'h0, 2'h3);
      for (k = 1; k < 4; k++) beat_is(base + k, k, 2'h0);
      $display("push tests done");
   endtask
   task automatic t_fault;
      cpi_slave_model_i.retry_at = cpi_slave_model_i.cnt + 1;
      push(4'hF, 1'b0, 1'b0);
      chk(nexc, 1);
      cpi_slave_model_i.retry_at = -1;
      cpi_slave_model_i.err_at = cpi_slave_model_i.cnt;
      push(4'h1, 1'b0, 1'b0);
      chk(nexc, 1);
      chk(cpi_slave_model_i.cnt - base, 0);
      victim_in.way = 2'h2;
      push(4'h3, 1'b0, 1'b1);
      chk({nrst[1:0], rway}, {2'h1, 2'h2});
      chk(cpi_slave_model_i.cnt - base, 0);
      push(4'h3, 1'b1, 1'b0);
      chk(cpi_slave_model_i.log_q[base].lock, 1'b1);
      $display("fault tests done");
   endtask
   task automatic ic_go(input logic [3:0] op, input logic [1:0] m,
                        input logic [31:0] a);
      {ic_fill_in, ic_drop_in, ic_snoop_in, ic_snoop_write_in} = op;
      {ic_snoop_mode_in, ic_addr_in, ic_snoop_addr_in} = {m, a, a};
      ic_fill_data_in = {~a, a, 32'h0, a};
      tick(1);
      {ic_fill_in, ic_drop_in, ic_snoop_in, ic_snoop_write_in} = 4'h0;
   endtask
   task automatic look(input logic [31:0] a, input logic h);
      ic_fetch_in = 1'b1;
      ic_addr_in = a;
      tick(1);
      ic_fetch_in = 1'b0;
      hits += ic_hit_out;
      chk(ic_hit_out, h);
      if (h) chk(ic_data_out, a[3] ? {~(a ^ 32'h8), a ^ 32'h8} : {32'h0, a});
   endtask
   task automatic t_icache;
      int k;
      ic_go(4'h8, 2'h0, 32'h1230);
      look(32'h1230, 1'b1);
      look(32'h1238, 1'b1);
      ic_go(4'h4, 2'h0, 32'h1230);
      look(32'h1230, 1'b0);
      ic_go(4'h8, 2'h0, 32'h1230);
      ic_go(4'h2, 2'h1, 32'h1230);
      look(32'h1230, 1'b1);
      ic_go(4'h2, 2'h2, 32'h1230);
      look(32'h1230, 1'b0);
      ic_go(4'h8, 2'h0, 32'h1230);
      ic_go(4'h3, 2'h1, 32'h1230);
      look(32'h1230, 1'b0);
      for (k = 1; k < 6; k++) ic_go(4'h8, 2'h0, {k[23:0], 8'h50});
      hits = 0;
      // the evicted way is random: only the last fill must hit
      for (k = 1; k < 6; k++) begin
         ic_fetch_in = 1'b1;
         ic_addr_in = {k[23:0], 8'h50};
         tick(1);
         ic_fetch_in = 1'b0;
         hits += ic_hit_out;
         chk(ic_hit_out || k < 5, 1'b1);
         if (ic_hit_out) chk(ic_data_out, {32'h0, ic_addr_in});
      end
      chk(hits, 4);
      look(32'h550, 1'b1);
      $display("icache tests done");
   endtask
   task automatic test_done;
      $display("checks %0d mismatches %0d", checks, n_mismatch);
      if (n_mismatch == 0 && checks > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask
   initial begin
      repeat (20000) @(posedge clock_in);
      n_mismatch++;
      test_done;
   end
   initial begin
      {rstn_in, victim_valid_in, victim_inhibit_in, fill_done_in} = 4'h0;
      {fill_abort_in, snoop_valid_in, ic_fetch_in, ic_fill_in} = 4'h0;
      {ic_drop_in, ic_snoop_in, ic_snoop_write_in, ic_snoop_mode_in} = 5'h00;
      {ic_addr_in, ic_snoop_addr_in, ic_fill_data_in} = 192'h0;
      victim_in = '{28'h0123456, 128'hCAFE0003CAFE0002CAFE0001CAFE0000,
                    4'h0, 2'h1, 1'b0};
      snoop_line_in = 28'h0123456;
      tick(6);
      rstn_in = 1'b1;
      t_push;
      t_fault;
      t_icache;
      test_done;
   end
endmodule
`default_nettype wire

// ==== test/cpi_slave_model.sv ====
`timescale 1ns/1ps
`default_nettype none
// **************************
// memory slave on the bus
// **************************
module cpi_slave_model (
   input  wire logic               clock_in,
   input  wire logic               rstn_in,
   input  wire logic               bus_valid_in,
   input  wire cpi_pkg::cpi_beat_t beat_in,
   output logic                    ack_out,
   output logic                    err_out,
   output logic                    bi_out
);
   int                 wait_n = 0;
   int                 retry_at = -1;
   int                 err_at = -1;
   logic               bi_en = 1'b0;
   int                 cnt = 0;
   int                 wt = 0;
   cpi_pkg::cpi_beat_t log_q [16];
   initial {ack_out, err_out, bi_out} = 3'h0;
   // answers are cleared each falling edge and last one cycle; wait_n models a slow slave
   always @(negedge clock_in) begin
      {ack_out, err_out, bi_out} = 3'h0;
      if (rstn_in && bus_valid_in) begin
         if (wt < wait_n) begin
            wt++;
         end else begin
            wt = 0;
            ack_out = (cnt != err_at);
            err_out = (cnt == err_at) || (cnt == retry_at);
            if (cnt == retry_at) retry_at = -1;
            if (cnt == err_at) err_at = -1;
            bi_out = bi_en && beat_in.siz == 2'h3;
         end
      end
   end
   // every good beat is taken in order
   always @(posedge clock_in) begin
      if (ack_out && !err_out) begin
         log_q[cnt[3:0]] = beat_in;
         cnt++;
      end
   end
endmodule
`default_nettype wire
